// [design/cprb_cfg.svh]
// field positions, codes, reset values and timing constants of the program register bank
`ifndef CPRB_CFG_SVH
`define CPRB_CFG_SVH
// ===========================================================
// control word layout
`define CPRB_WORD_W 16
`define CPRB_ADDR_HI 10
`define CPRB_ADDR_LO 9
`define CPRB_LOAD_BIT 8
`define CPRB_CODE_HI 7
`define CPRB_CODE_LO 0
`define CPRB_SEL_LEFT 2'h0
`define CPRB_SEL_RIGHT 2'h1
`define CPRB_SEL_FUNC 2'h2
`define CPRB_SEL_FMT 2'h3
// converter function word bits
`define CPRB_B_ADC_PD 8
`define CPRB_B_HPF_BYP 7
`define CPRB_B_DAC_PD 6
`define CPRB_B_COMMON 5
`define CPRB_B_ZDET 4
`define CPRB_B_FORCE 3
`define CPRB_B_DEEM_HI 2
`define CPRB_B_DEEM_LO 1
`define CPRB_B_MUTE 0
// interface format word bits
`define CPRB_B_LOOP 5
`define CPRB_B_FMT_HI 3
`define CPRB_B_FMT_LO 2
`define CPRB_B_LRP 1
// ===========================================================
// codes and reset values
`define CPRB_CODE_RST 8'hff
`define CPRB_CODE_MUTE 8'h00
`define CPRB_DEEM_441 2'h0
`define CPRB_DEEM_OFF 2'h1
`define CPRB_DEEM_48 2'h2
`define CPRB_DEEM_32 2'h3
`define CPRB_FMT_0 2'h0
`define CPRB_FMT_1 2'h1
`define CPRB_FMT_2 2'h2
`define CPRB_FMT_3 2'h3
// ===========================================================
// bit counting and soft ramp timing
`define CPRB_CNT_W 5
`define CPRB_CNT_ONE 5'h01
`define CPRB_CNT_FULL 5'h10
`define CPRB_CLK_MHZ 50
`define CPRB_RAMP_STEP_NS 100
`define CPRB_RAMP_STEP_CYC ((`CPRB_RAMP_STEP_NS * `CPRB_CLK_MHZ + 999) / 1000)
`define CPRB_RAMP_CNT_W 3
`endif

// [design/cprb_pkg.sv]
// shared types of the program register bank
package cprb_pkg;
    // ===========================================================
    // converter function settings
    typedef struct packed {
        logic adc_powerdown;       // adc section powered down
        logic hpf_bypass;          // adc high-pass filter bypassed
        logic dac_powerdown;       // dac section powered down
        logic common_atten_mode;   // left code drives both channels
        logic zero_detect_mute_en; // infinite zero detect mute
        logic output_force;        // dac outputs forced to bipolar zero
        logic [1:0] deemph_select; // de-emphasis code
        logic soft_mute_en;        // soft mute both channels
    } cprb_func_t;
    // interface format settings
    typedef struct packed {
        logic loopback_en;            // adc data looped to dac
        logic [1:0] audio_format_sel; // audio data format code
        logic lr_clock_polarity;      // lr clock polarity swap
    } cprb_fmt_t;
    // per-channel attenuation codes
    typedef struct packed {
        logic [7:0] left;  // left channel code
        logic [7:0] right; // right channel code
    } cprb_atten_t;
    // decoded de-emphasis, one-hot
    typedef struct packed {
        logic off;   // de-emphasis off
        logic fs32;  // 32 kHz curve
        logic fs441; // 44.1 kHz curve
        logic fs48;  // 48 kHz curve
    } cprb_deemph_t;
    // decoded audio format
    typedef struct packed {
        logic word20;        // 20-bit samples, else 16-bit
        logic dac_left_just; // dac left-justified
        logic adc_left_just; // adc left-justified
        logic i2s;           // both sides i2s
    } cprb_fmtdec_t;
endpackage

// [design/cprb_sync.sv]
// two flip-flop level synchroniser into the system clock domain
`timescale 1ns/10ps
module cprb_sync (
    input wire logic clk,  // system clock
    input wire logic srst, // synchronous reset, active high
    input wire logic d,    // asynchronous level
    output logic q         // synchronised level
);
    logic meta_q; // first stage, read only by the second

    // ===========================================================
    // two stages; the first may go metastable
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// [design/cprb_link_shift.sv]
// serial control shifter running on the serial control clock
`timescale 1ns/10ps
`include "cprb_cfg.svh"
module cprb_link_shift (
    input wire logic serial_ctrl_clock,           // link clock, stands still between words
    input wire logic srst,                        // reset, taken asynchronously here
    input wire logic serial_ctrl_data,            // data, synchronous to the link clock
    output logic [`CPRB_WORD_W-1:0] shift_word,   // last bits shifted in, msb first
    output logic bit_toggle                       // flips once per bit received
);
    // ===========================================================
    // shifter; the link clock may be stopped during reset, so the
    // reset acts without it and the flops hold constants only
    always_ff @(posedge serial_ctrl_clock or posedge srst) begin
        if (srst) begin
            shift_word <= '0;
            bit_toggle <= 1'b0;
        end else begin
            // msb arrives first and moves up [RQ16]
            shift_word <= {shift_word[`CPRB_WORD_W-2:0], serial_ctrl_data};
            bit_toggle <= ~bit_toggle;
        end
    end
endmodule

// [design/cprb_top.sv]
// program register bank: serial word capture, decode, apply and soft ramp
`timescale 1ns/10ps
`include "cprb_cfg.svh"
// Overview of operation
// [RQ1] four sixteen-bit write-only program registers
// [RQ2] host writes zeros into bits fifteen-eleven
// [RQ3] bits ten-nine choose the target register
// [RQ4] left load strobe bit8, left code 7-0
// [RQ5] right load strobe bit8, right code 7-0
// [RQ6] strobe set applies code, clear keeps level
// [RQ7] either strobe updates both channels together
// [RQ8] code over 256 sets level, ff unity
// [RQ9] code bit seven is msb, zero lsb
// [RQ10] function register bits placed as mapped
// [RQ11] format register loopback, format, polarity bits
// [RQ12] common mode: left code drives both channels
// [RQ13] de-emphasis codes: 441, off, 48, 32
// [RQ14] format codes: 16rj, 20rj, 20lj, i2s
// [RQ15] soft mute ramps both channels down together
// [RQ16] word commits on latch rise after bits
// [RQ17] reset restores all documented defaults
module cprb_top (
    input wire logic clk,                           // system clock, 50 MHz
    input wire logic srst,                          // synchronous reset, active high
    input wire logic serial_ctrl_clock,             // serial control clock pin
    input wire logic serial_ctrl_data,              // serial control data pin
    input wire logic serial_ctrl_latch,             // serial control latch pin
    output cprb_pkg::cprb_atten_t atten_code,       // applied codes after common mode
    output cprb_pkg::cprb_atten_t atten_level,      // ramped level seen by the filter
    output cprb_pkg::cprb_func_t func_ctrl,         // converter function settings
    output cprb_pkg::cprb_fmt_t fmt_ctrl,           // interface format settings
    output cprb_pkg::cprb_deemph_t deemph_mode,     // decoded de-emphasis
    output cprb_pkg::cprb_fmtdec_t format_mode,     // decoded audio format
    output logic word_commit,                       // pulse: a word was committed
    output logic word_refused                       // pulse: latch seen with short word
);
    // ===========================================================
    // declarations
    localparam logic [`CPRB_RAMP_CNT_W-1:0] ramp_last =
        `CPRB_RAMP_CNT_W'(`CPRB_RAMP_STEP_CYC - 1);     // last count of a ramp step
    localparam cprb_pkg::cprb_func_t func_rst =
        '{deemph_select: `CPRB_DEEM_OFF, default: '0}; // de-emphasis off, rest clear
    logic [`CPRB_WORD_W-1:0] link_word;  // shifter contents, link domain
    logic link_toggle;                   // bit event toggle, link domain
    logic tgl_s;                         // synchronised toggle
    logic tgl_d1_q;                      // toggle one cycle later
    logic latch_s;                       // synchronised latch
    logic latch_d1_q;                    // latch one cycle later
    logic [`CPRB_WORD_W-1:0] snap_q;     // word copy in the system domain
    logic [`CPRB_CNT_W-1:0] cnt_q;       // bits seen since the last latch
    logic [`CPRB_CNT_W-1:0] cnt_d;       // next bit count
    logic [7:0] pend_l_q;                // last written left code
    logic [7:0] pend_r_q;                // last written right code
    logic [7:0] pend_l_d;                // next left written code
    logic [7:0] pend_r_d;                // next right written code
    logic [7:0] app_l_q;                 // applied left code
    logic [7:0] app_r_q;                 // applied right code
    logic [7:0] app_l_d;                 // next applied left code
    logic [7:0] app_r_d;                 // next applied right code
    cprb_pkg::cprb_func_t func_d;        // next function settings
    cprb_pkg::cprb_fmt_t fmt_d;          // next format settings
    cprb_pkg::cprb_func_t func_w;        // function fields of the word
    cprb_pkg::cprb_fmt_t fmt_w;          // format fields of the word
    cprb_pkg::cprb_atten_t code_d;       // next applied codes after common mode
    cprb_pkg::cprb_atten_t tgt_w;        // ramp targets
    logic [`CPRB_RAMP_CNT_W-1:0] ramp_cnt_q; // ramp step timer
    cprb_pkg::cprb_atten_t lvl_d;        // next ramped levels

    // ===========================================================
    // helpers
    // one ramp step of a level towards its target
    function automatic logic [7:0] ramp_step(input logic [7:0] cur, input logic [7:0] tgt);
        if (cur < tgt) begin
            ramp_step = cur + 8'h01;
        end else if (cur > tgt) begin
            ramp_step = cur - 8'h01;
        end else begin
            ramp_step = cur;
        end
    endfunction

    // ===========================================================
    // link side shifter and crossings
    cprb_link_shift u_link (
        .serial_ctrl_clock(serial_ctrl_clock),
        .srst(srst),
        .serial_ctrl_data(serial_ctrl_data),
        .shift_word(link_word),
        .bit_toggle(link_toggle)
    );
    cprb_sync u_sync_tgl (
        .clk(clk),
        .srst(srst),
        .d(link_toggle),
        .q(tgl_s)
    );
    // keep the latch low through reset: a high level at release reads as a
    // rise, and the empty word behind it is refused
    cprb_sync u_sync_latch (
        .clk(clk),
        .srst(srst),
        .d(serial_ctrl_latch),
        .q(latch_s)
    );

    // ===========================================================
    // word capture and commit decision
    wire bit_evt = tgl_s ^ tgl_d1_q;          // a bit arrived on the link
    wire latch_rise = latch_s & ~latch_d1_q;  // latch went high
    wire word_full = (cnt_q == `CPRB_CNT_FULL); // a whole word is in
    wire commit_w = latch_rise & word_full;   // commit only after a full word [RQ16]
    wire refuse_w = latch_rise & ~word_full;  // latch too early: word dropped [RQ16]

    // bit count: a bit in the latch cycle counts for the next word
    always_comb begin
        cnt_d = cnt_q;
        if (latch_rise) begin
            cnt_d = bit_evt ? `CPRB_CNT_ONE : '0; // [RQ16]
        end else if (bit_evt && !word_full) begin
            cnt_d = cnt_q + `CPRB_CNT_ONE;
        end
    end

    // the link word is copied only after its toggle has crossed, so it
    // has been still for two cycles; a bit takes at least five cycles
    always_ff @(posedge clk) begin
        if (srst) begin
            tgl_d1_q <= 1'b0;
            latch_d1_q <= 1'b0;
            snap_q <= '0;
            cnt_q <= '0;
        end else begin
            tgl_d1_q <= tgl_s;
            latch_d1_q <= latch_s;
            snap_q <= bit_evt ? link_word : snap_q;
            cnt_q <= cnt_d;
        end
    end

    // ===========================================================
    // address decode and field extraction
    wire [1:0] addr_w = snap_q[`CPRB_ADDR_HI:`CPRB_ADDR_LO]; // register select [RQ3]
    wire sel_left = (addr_w == `CPRB_SEL_LEFT);
    wire sel_right = (addr_w == `CPRB_SEL_RIGHT);
    wire sel_func = (addr_w == `CPRB_SEL_FUNC);
    wire sel_fmt = (addr_w == `CPRB_SEL_FMT);
    // bits above the address are ignored; the host keeps them zero [RQ2]
    wire load_bit = snap_q[`CPRB_LOAD_BIT];                  // [RQ4] [RQ5]
    wire [7:0] code_w = snap_q[`CPRB_CODE_HI:`CPRB_CODE_LO]; // msb first [RQ9]
    wire load_l = commit_w & sel_left & load_bit;   // [RQ4]
    wire load_r = commit_w & sel_right & load_bit;  // [RQ5]
    wire apply_w = load_l | load_r;                 // either strobe loads both [RQ7]

    // function and format fields as laid out in the word
    assign func_w.adc_powerdown = snap_q[`CPRB_B_ADC_PD];       // [RQ10]
    assign func_w.hpf_bypass = snap_q[`CPRB_B_HPF_BYP];
    assign func_w.dac_powerdown = snap_q[`CPRB_B_DAC_PD];
    assign func_w.common_atten_mode = snap_q[`CPRB_B_COMMON];
    assign func_w.zero_detect_mute_en = snap_q[`CPRB_B_ZDET];
    assign func_w.output_force = snap_q[`CPRB_B_FORCE];
    assign func_w.deemph_select = snap_q[`CPRB_B_DEEM_HI:`CPRB_B_DEEM_LO];
    assign func_w.soft_mute_en = snap_q[`CPRB_B_MUTE];
    assign fmt_w.loopback_en = snap_q[`CPRB_B_LOOP];            // [RQ11]
    assign fmt_w.audio_format_sel = snap_q[`CPRB_B_FMT_HI:`CPRB_B_FMT_LO];
    assign fmt_w.lr_clock_polarity = snap_q[`CPRB_B_LRP];

    // ===========================================================
    // next register values
    // a code written with its strobe clear waits for a later strobe [RQ6]
    assign pend_l_d = (commit_w & sel_left) ? code_w : pend_l_q;
    assign pend_r_d = (commit_w & sel_right) ? code_w : pend_r_q;
    assign app_l_d = apply_w ? pend_l_d : app_l_q;  // [RQ6] [RQ7]
    assign app_r_d = apply_w ? pend_r_d : app_r_q;  // [RQ6] [RQ7]
    assign func_d = (commit_w & sel_func) ? func_w : func_ctrl; // [RQ10]
    assign fmt_d = (commit_w & sel_fmt) ? fmt_w : fmt_ctrl;     // [RQ11]
    // common mode ignores the right code while it is set [RQ12]
    assign code_d.left = app_l_d;
    assign code_d.right = func_d.common_atten_mode ? app_l_d : app_r_d;

    // ===========================================================
    // program registers; reset gives unity gain and format 0 [RQ17]
    // four words held: two attenuation codes, function and format [RQ1]
    always_ff @(posedge clk) begin
        if (srst) begin
            pend_l_q <= `CPRB_CODE_RST;
            pend_r_q <= `CPRB_CODE_RST;
            app_l_q <= `CPRB_CODE_RST;
            app_r_q <= `CPRB_CODE_RST;
            atten_code <= {`CPRB_CODE_RST, `CPRB_CODE_RST};
            func_ctrl <= func_rst;
            fmt_ctrl <= '0;
            word_commit <= 1'b0;
            word_refused <= 1'b0;
        end else begin
            pend_l_q <= pend_l_d;
            pend_r_q <= pend_r_d;
            app_l_q <= app_l_d;
            app_r_q <= app_r_d;
            atten_code <= code_d;
            func_ctrl <= func_d;
            fmt_ctrl <= fmt_d;
            word_commit <= commit_w;
            word_refused <= refuse_w;
        end
    end

    // ===========================================================
    // decoded modes, registered from the next settings
    always_ff @(posedge clk) begin
        if (srst) begin
            deemph_mode <= '{off: 1'b1, default: 1'b0};
            format_mode <= '{adc_left_just: 1'b1, default: 1'b0};
        end else begin
            deemph_mode.fs441 <= (func_d.deemph_select == `CPRB_DEEM_441); // [RQ13]
            deemph_mode.off <= (func_d.deemph_select == `CPRB_DEEM_OFF);
            deemph_mode.fs48 <= (func_d.deemph_select == `CPRB_DEEM_48);
            deemph_mode.fs32 <= (func_d.deemph_select == `CPRB_DEEM_32);
            format_mode.word20 <= (fmt_d.audio_format_sel != `CPRB_FMT_0); // [RQ14]
            format_mode.dac_left_just <= (fmt_d.audio_format_sel == `CPRB_FMT_2);
            format_mode.adc_left_just <= (fmt_d.audio_format_sel != `CPRB_FMT_3);
            format_mode.i2s <= (fmt_d.audio_format_sel == `CPRB_FMT_3);
        end
    end

    // ===========================================================
    // soft ramp: the level steps one code per tick towards its target,
    // so mute fades instead of clicking; both channels share the tick
    wire ramp_tick = (ramp_cnt_q == ramp_last);
    // code 00 is full mute, ff unity; the filter scales by code/256 [RQ8]
    assign tgt_w.left = func_ctrl.soft_mute_en ? `CPRB_CODE_MUTE : atten_code.left;  // [RQ15]
    assign tgt_w.right = func_ctrl.soft_mute_en ? `CPRB_CODE_MUTE : atten_code.right; // [RQ15]
    // next level: one step at each tick, held in between; a target change
    // in mid-ramp just turns the walk round, so no step is ever skipped
    assign lvl_d.left = ramp_tick ? ramp_step(atten_level.left, tgt_w.left)
        : atten_level.left; // [RQ15]
    assign lvl_d.right = ramp_tick ? ramp_step(atten_level.right, tgt_w.right)
        : atten_level.right; // [RQ15]

    always_ff @(posedge clk) begin
        if (srst) begin
            ramp_cnt_q <= '0;
            atten_level <= {`CPRB_CODE_RST, `CPRB_CODE_RST};
        end else begin
            ramp_cnt_q <= ramp_tick ? '0 : ramp_cnt_q + 1'b1;
            atten_level <= lvl_d; // [RQ15]
        end
    end

    // ===========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    left_load_apply_a: assert property (load_l |=> atten_code.left == $past(code_w)) // [RQ6]
        else $error("left code not applied after strobed write");
    strobe_clear_hold_a: assert property ( // [RQ6]
        (commit_w && sel_left && !load_bit) |=> $stable(app_l_q) && $stable(app_r_q))
        else $error("attenuation changed on a write without strobe");
    joint_update_a: assert property (load_r |=> app_l_q == $past(pend_l_q)) // [RQ7]
        else $error("left channel not updated with right strobe");
    right_load_apply_a: assert property (load_r |=> app_r_q == $past(code_w)) // [RQ5]
        else $error("right code not applied after strobed write");
    fmt_field_a: assert property ((commit_w && sel_fmt) |=> fmt_ctrl == $past(fmt_w)) // [RQ11]
        else $error("format word fields misplaced");
    level_hold_a: assert property (!ramp_tick |=> $stable(atten_level)) // [RQ15]
        else $error("level moved between ramp ticks");
    commit_pulse_a: assert property (commit_w |=> word_commit && !word_refused) // [RQ16]
        else $error("commit pulse missing after a full word");
    common_mode_a: assert property ( // [RQ12]
        func_ctrl.common_atten_mode |-> atten_code.right == atten_code.left)
        else $error("common mode does not copy left code to right");
    func_field_a: assert property ( // [RQ10]
        (commit_w && sel_func) |=> func_ctrl.soft_mute_en == $past(snap_q[`CPRB_B_MUTE])
            && func_ctrl.adc_powerdown == $past(snap_q[`CPRB_B_ADC_PD]))
        else $error("function word fields misplaced");
    no_commit_stable_a: assert property ( // [RQ16]
        !commit_w |=> $stable(func_ctrl) && $stable(fmt_ctrl) && $stable(atten_code))
        else $error("settings changed without a latch commit");
    short_word_drop_a: assert property (refuse_w |=> !word_commit ##1 cnt_q <= `CPRB_CNT_ONE)
        else $error("short word not refused"); // [RQ16]
    deemph_decode_a: assert property ( // [RQ13]
        $onehot(deemph_mode) && (deemph_mode.off == (func_ctrl.deemph_select == `CPRB_DEEM_OFF)))
        else $error("de-emphasis decode wrong");
    format_decode_a: assert property ( // [RQ14]
        (fmt_ctrl.audio_format_sel == `CPRB_FMT_3) == format_mode.i2s
            && (fmt_ctrl.audio_format_sel == `CPRB_FMT_0) == !format_mode.word20)
        else $error("format decode wrong");
    mute_fall_a: assert property ( // [RQ15]
        (func_ctrl.soft_mute_en && $past(func_ctrl.soft_mute_en) && ramp_tick)
            |=> atten_level.left <= $past(atten_level.left)
            && atten_level.right <= $past(atten_level.right))
        else $error("level rises under soft mute");
    reset_default_a: assert property ($past(srst) |-> atten_code == {`CPRB_CODE_RST, // [RQ17]
        `CPRB_CODE_RST} && func_ctrl == func_rst && fmt_ctrl == '0)
        else $error("reset defaults wrong");

    left_strobe_c: cover property (load_l ##1 atten_code.left != `CPRB_CODE_RST);
    mute_zero_c: cover property (func_ctrl.soft_mute_en && atten_level.left == `CPRB_CODE_MUTE);
    common_c: cover property (func_ctrl.common_atten_mode && load_r);
    refused_c: cover property (refuse_w);
    fmt_c: cover property (commit_w && sel_fmt);
endmodule

// [tb/cprb_host_model.sv]
// host model driving the three-wire serial control port
`timescale 1ns/10ps
module cprb_host_model (
    output logic serial_ctrl_clock, // link clock, still between words
    output logic serial_ctrl_data,  // serial data, msb first
    output logic serial_ctrl_latch  // latch strobe, active high
);
    // ===========================================================
    // idle levels
    initial begin
        serial_ctrl_clock = 1'b0;
        serial_ctrl_data = 1'b0;
        serial_ctrl_latch = 1'b0;
    end
    // ===========================================================
    // one frame: nb bits of w, msb first, then a latch pulse
    // the clock runs slower than the 20 ns tick because the port needs >= 100 ns per bit
    task automatic send_word(input logic [15:0] w, input int nb);
        int i;
        #7;
        for (i = nb - 1; i >= 0; i--) begin
            serial_ctrl_data = w[i];
            #60 serial_ctrl_clock = 1'b1;
            #60 serial_ctrl_clock = 1'b0;
            serial_ctrl_data = ~w[i]; // hold time over: line no longer valid
        end
        #60 serial_ctrl_latch = 1'b1;
        #90 serial_ctrl_latch = 1'b0;
        #150;
    endtask
endmodule

// [tb/codec_program_register_bank_test.sv]
// self-checking bench of the program register bank
`timescale 1ns/10ps
module codec_program_register_bank_test;
    logic clk = 1'b0; // system clock
    logic srst = 1'b1; // reset, active high
    wire logic sck, sda, slat; // serial pins from the host model
    cprb_pkg::cprb_atten_t atten_code, atten_level;
    cprb_pkg::cprb_func_t func_ctrl;
    cprb_pkg::cprb_fmt_t fmt_ctrl;
    cprb_pkg::cprb_deemph_t deemph_mode;
    cprb_pkg::cprb_fmtdec_t format_mode;
    logic word_commit, word_refused; // answer pulses
    int errors = 0, n_tests = 0, n_com = 0, n_ref = 0, k;
    logic [31:0] seed = 32'hbf5551e9; // fixed seed keeps runs repeatable
    logic [15:0] w;
    logic [7:0] pl, pr, al, ar; // model pending and applied codes
    logic [8:0] fn; // model function word
    logic [3:0] fm; // model format word
    always #10 clk = ~clk;
    cprb_host_model cprb_host_model_inst (.serial_ctrl_clock(sck), .serial_ctrl_data(sda),
        .serial_ctrl_latch(slat));
    cprb_top cprb_top_inst (.clk(clk), .srst(srst), .serial_ctrl_clock(sck),
        .serial_ctrl_data(sda), .serial_ctrl_latch(slat), .atten_code(atten_code),
        .atten_level(atten_level), .func_ctrl(func_ctrl), .fmt_ctrl(fmt_ctrl),
        .deemph_mode(deemph_mode), .format_mode(format_mode), .word_commit(word_commit),
        .word_refused(word_refused));
    // count the one-cycle answer pulses, looked at mid-cycle where they are settled
    always @(negedge clk) begin
        if (word_commit === 1'b1) n_com++;
        if (word_refused === 1'b1) n_ref++;
    end
    // ===========================================================
    // expectation helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // one-hot de-emphasis: off, 32, 44.1, 48
    function automatic logic [3:0] dm(input logic [1:0] d);
        return (d == 2'h1) ? 4'h8 : (d == 2'h3) ? 4'h4 : (d == 2'h0) ? 4'h2 : 4'h1;
    endfunction
    // decoded format: word20, dac left, adc left, i2s
    function automatic logic [3:0] fd(input logic [1:0] f);
        return (f == 2'h0) ? 4'h2 : (f == 2'h1) ? 4'ha : (f == 2'h2) ? 4'he : 4'h9;
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_all();
        chk("atten_code", {al, fn[5] ? al : ar}, atten_code);
        chk("func_ctrl", {7'h0, fn}, {7'h0, func_ctrl});
        chk("fmt_ctrl", {12'h0, fm}, {12'h0, fmt_ctrl});
        chk("deemph_mode", {12'h0, dm(fn[2:1])}, {12'h0, deemph_mode});
        chk("format_mode", {12'h0, fd(fm[2:1])}, {12'h0, format_mode});
    endtask
    // ===========================================================
    // send one frame, update the model, compare
    task automatic put(input logic [15:0] wd, input int nb);
        int c0, r0, i;
        c0 = n_com;
        r0 = n_ref;
        cprb_host_model_inst.send_word(wd, nb);
        for (i = 0; i < 20 && n_com == c0 && n_ref == r0; i++) @(posedge clk);
        if (i == 20) begin
            errors++;
            $display("[ERR] answer_pulse expected 1 seen 0");
            print_verdict();
        end
        #1;
        if (nb < 16) begin
            chk("word_refused", 16'h1, 16'(n_ref - r0));
        end else begin
            chk("word_commit", 16'h1, 16'(n_com - c0));
            case (wd[10:9])
                2'h0: pl = wd[7:0];
                2'h1: pr = wd[7:0];
                2'h2: fn = wd[8:0];
                default: fm = {wd[5], wd[3:2], wd[1]};
            endcase
            if (wd[10:9] < 2'h2 && wd[8]) begin
                al = pl;
                ar = pr;
            end
        end
        chk_all();
    endtask
    task automatic rst();
        @(posedge clk) srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        {pl, pr, al, ar, fn, fm} = {32'hffffffff, 9'h002, 4'h0};
        @(posedge clk);
        #1;
        chk("atten_level", 16'hffff, atten_level);
        chk_all();
        repeat (2) @(posedge clk);
        $display("test reset done");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ===========================================================
    // main sequence
    initial begin
        rst();
        put(16'h0012, 16); // left code, strobe clear: held pending
        put(16'h0334, 16); // right strobe applies both together
        put(16'h0101, 16); // lsb only code
        put(16'h0555, 12); // short word is refused
        put(16'h0422, 16); // common mode on
        $display("test strobe and common done");
        for (k = 0; k < 4; k++) begin
            put(16'h0400 | 16'(k << 1), 16);
            put(16'h0600 | 16'(k << 2), 16);
        end
        $display("test codes done");
        for (k = 0; k < 40; k++) begin
            seed = xs(seed);
            w = {5'h0, seed[10:0]}; // reserved bits kept zero
            if (w[10:9] == 2'h3) w &= 16'h062e;
            put(w, 16);
        end
        $display("test random done");
        put(16'h0401, 16); // soft mute
        repeat (1300) @(posedge clk);
        #1;
        chk("atten_level", 16'h0000, atten_level);
        $display("test mute done");
        rst();
        print_verdict();
    end
    // cut a hang short
    initial begin
        #1500000;
        errors++;
        print_verdict();
    end
endmodule
